// File: common/irt_defs.svh
/*
  Shared constants for the infrared command transmitter: timing figures,
  matrix sizes, frame layout and APB register map.
  Assumes a 125 MHz pclk and an 80 kHz nominal internal key-scan clock.
*/
`ifndef IRT_DEFS_SVH
`define IRT_DEFS_SVH

// Timing figures in nanoseconds
`define IRT_PCLK_NS       8
`define IRT_TICK_NS       12500
// Scan clock enable divider, derived from the two periods
`define IRT_TICK_DIV      (`IRT_TICK_NS / `IRT_PCLK_NS)

// Matrix and code layout
`define IRT_STROBES       8
`define IRT_KEY_INPUTS    4
`define IRT_SHIFTS        3
`define IRT_CODE_BITS     8
`define IRT_FRAME_BITS    16

// Frame timing in scan ticks (one pulse period is two ticks)
`define IRT_STROBE_TICKS  16
`define IRT_SAMPLE_POS    4'hf
`define IRT_SCAN_TICKS    (`IRT_STROBES * `IRT_STROBE_TICKS)
`define IRT_SLOT_TICKS    128
`define IRT_ZERO_TICKS    64
`define IRT_ONE_TICKS     96
`define IRT_TX_TICKS      (`IRT_FRAME_BITS * `IRT_SLOT_TICKS)
`define IRT_CYCLE_TICKS   8192
`define IRT_CYC_W         13

// APB register map
`define IRT_ADDR_W        12
`define IRT_REG_CTRL      12'h000
`define IRT_REG_STATUS    12'h004
`define IRT_REG_CODE      12'h008
`define IRT_CTRL_EN_BIT   0
`define IRT_CTRL_RESET    1'h1
`define IRT_ST_STBY_BIT   0
`define IRT_ST_TXACT_BIT  1
`define IRT_ST_SENT_BIT   2
`define IRT_ST_INVAL_BIT  3

`endif

// File: common/irt_pkg.sv
/*
  Types for the infrared command transmitter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irt_pkg;

  typedef enum logic [0:0] {
    IRT_STANDBY = 1'b0,
    IRT_RUN     = 1'b1
  } irt_state_e;

  typedef logic [7:0] irt_code_t;

endpackage : irt_pkg

// File: verilog/irt_transmitter.sv
/*
  Infrared remote command transmitter: key matrix scanner, command former,
  pulse-burst modulator and APB register slave, all in one module.
  Assumes pclk at 125 MHz, key, shift and mode pins asynchronous to pclk,
  open-drain strobe and active pins resolved outside with pull-ups.
*/
// Contract
// (RULE1) Reset puts the device in standby: clock stopped, pull-ups off, strobes low.
// (RULE2) In standby any key press wakes the device and releases the strobes.
// (RULE3) Eight active-low open-drain strobes scan the matrix once per cycle.
// (RULE4) Transmission starts only after a full scan has finished.
// (RULE5) Scan and send repeat until a scan finds no key, then standby.
// (RULE6) Two or more inputs active in one strobe slot make the scan invalid.
// (RULE7) Inputs active in two different strobe slots make the scan invalid.
// (RULE8) An invalid scan sends nothing; scanning continues until valid or idle.
// (RULE9) The keyboard presents four active-low inputs, at most one active.
// (RULE10) Transmitter-active output is pulled low during a transmitting cycle.
// (RULE11) Transmit output idles low, pulses high at half clock rate.
// (RULE12) A command is the 8-bit code followed by its complement.
// (RULE13) Both bytes are sent least significant bit first.
// (RULE14) Zero is a burst of 32 pulses, one is 48, sixteen bursts total.
// (RULE15) Pulses at 40 kHz, 1.6 ms slots, then silence for the cycle.
// (RULE16) Three shift inputs extend 32 matrix codes to 0 through 255.
// (RULE17) Shift 3, 2, 1 give code bits 7, 6, 5; high input gives zero.
// (RULE18) Single-shot sends once per press, then waits for release and standby.
// (RULE19) Single-shot accepts up to five commands per second.
// (RULE20) Single-shot input low makes every code single-shot.
// (RULE21) Mode input low makes codes 128-255 single-shot; both high is continuous.
// (RULE22) In standby the single-shot and mode inputs are pulled low internally.
// (RULE23) Each slot spans 64 pulse periods; bursts lead, the rest is silent.
// (RULE24) All scan and burst timing is counted from the system clock.
`timescale 1ns/1ps
`include "irt_defs.svh"

module irt_transmitter #(
  parameter int TICK_DIV    = `IRT_TICK_DIV,
  parameter int CYCLE_TICKS = `IRT_CYCLE_TICKS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`IRT_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [`IRT_KEY_INPUTS-1:0] key_n,
  input  wire logic [`IRT_SHIFTS-1:0]    shift_n,
  input  wire logic                      single_n,
  input  wire logic                      mode_sel,
  output logic      [`IRT_STROBES-1:0]   strobe_o,
  output logic      [`IRT_STROBES-1:0]   strobe_oe_n,
  output logic                           txact_o,
  output logic                           txact_oe_n,
  output logic                           tx_out,
  output logic                           osc_run,
  output logic                           pullup_en,
  output logic                           mode_pulldown_en
);

  localparam int SCAN_TICKS = `IRT_SCAN_TICKS;
  localparam int TX_END     = `IRT_SCAN_TICKS + `IRT_TX_TICKS;

  if (TICK_DIV < 2 || TICK_DIV > 4095) begin : g_bad_div
    $error("TICK_DIV out of range");
  end
  if (CYCLE_TICKS <= TX_END || CYCLE_TICKS > (1 << `IRT_CYC_W)) begin : g_bad_cycle
    $error("CYCLE_TICKS cannot hold scan and frame");
  end

  function automatic logic [2:0] irt_popcount(input logic [3:0] v);
    irt_popcount = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction : irt_popcount

  function automatic logic [1:0] irt_index(input logic [3:0] v);
    irt_index = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction : irt_index

  // Pin synchronisers
  logic [`IRT_KEY_INPUTS-1:0] key_m_r;
  logic [`IRT_KEY_INPUTS-1:0] key_s_r;
  logic [`IRT_SHIFTS-1:0]     shift_m_r;
  logic [`IRT_SHIFTS-1:0]     shift_s_r;
  logic [1:0]                 mode_m_r;
  logic [1:0]                 mode_s_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_m_r   <= 4'hf;
      key_s_r   <= 4'hf;
      shift_m_r <= 3'h7;
      shift_s_r <= 3'h7;
      mode_m_r  <= 2'h3;
      mode_s_r  <= 2'h3;
    end else begin
      key_m_r   <= key_n;
      key_s_r   <= key_m_r;
      shift_m_r <= shift_n;
      shift_s_r <= shift_m_r;
      mode_m_r  <= {single_n, mode_sel};
      mode_s_r  <= mode_m_r;
    end
  end

  irt_pkg::irt_state_e        state_r;
  logic                       ctrl_en_r;
  logic [11:0]                div_r;
  logic [`IRT_CYC_W-1:0]      cyc_r;
  logic                       found_r;
  logic                       multi_r;
  logic [2:0]                 hit_strobe_r;
  logic [1:0]                 hit_input_r;
  irt_pkg::irt_code_t         code_r;
  logic                       tx_en_r;
  logic                       sent_r;
  logic                       inval_r;
  logic                       tx_r;
  logic [`IRT_STROBES-1:0]    strobe_oe_n_r;
  logic [31:0]                prdata_r;

  logic                       run_w;
  logic                       key_any_w;
  logic                       tick_w;
  logic                       cyc_last_w;
  logic                       sample_w;
  logic                       scan_end_w;
  logic [3:0]                 act_w;
  logic [2:0]                 cnt_w;
  logic                       found_w;
  logic                       multi_w;
  logic [2:0]                 hit_strobe_w;
  logic [1:0]                 hit_input_w;
  irt_pkg::irt_code_t         code_w;
  logic                       single_w;

  assign run_w      = (state_r == irt_pkg::IRT_RUN);
  assign key_any_w  = ~&key_s_r;
  assign tick_w     = run_w && (div_r == 12'(TICK_DIV - 1)); // [RULE24]
  assign cyc_last_w = (cyc_r == `IRT_CYC_W'(CYCLE_TICKS - 1));
  assign sample_w   = tick_w && (cyc_r < `IRT_CYC_W'(SCAN_TICKS))
                      && (cyc_r[3:0] == `IRT_SAMPLE_POS);
  assign scan_end_w = sample_w && (cyc_r == `IRT_CYC_W'(SCAN_TICKS - 1)); // [RULE4]
  assign act_w      = ~key_s_r; // [RULE9]
  assign cnt_w      = irt_popcount(act_w);

  // Scan verdict including the final strobe slot
  always_comb begin
    found_w      = found_r;
    multi_w      = multi_r;
    hit_strobe_w = hit_strobe_r;
    hit_input_w  = hit_input_r;
    if (cnt_w > 3'h1) begin
      multi_w = 1'b1; // [RULE6]
    end else if (cnt_w == 3'h1) begin
      if (found_r) begin
        multi_w = 1'b1; // [RULE7]
      end
      found_w      = 1'b1;
      hit_strobe_w = cyc_r[6:4];
      hit_input_w  = irt_index(act_w);
    end
  end

  assign code_w   = {~shift_s_r, hit_strobe_w, hit_input_w}; // [RULE16] [RULE17]
  assign single_w = !mode_s_r[1] || (!mode_s_r[0] && code_w[7]); // [RULE20] [RULE21]

  // Run/standby sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= irt_pkg::IRT_STANDBY; // [RULE1]
    end else if (!ctrl_en_r) begin
      state_r <= irt_pkg::IRT_STANDBY;
    end else if (!run_w && key_any_w) begin
      state_r <= irt_pkg::IRT_RUN; // [RULE2]
    end else if (scan_end_w && !found_w && !multi_w) begin
      state_r <= irt_pkg::IRT_STANDBY; // [RULE5] [RULE18]
    end
  end

  // Scan-clock divider and cycle position, held at zero in standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 12'h000;
      cyc_r <= '0;
    end else if (!run_w) begin
      div_r <= 12'h000;
      cyc_r <= '0;
    end else if (tick_w) begin
      div_r <= 12'h000;
      cyc_r <= cyc_last_w ? '0 : cyc_r + 1'b1; // [RULE5]
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // Key detection across the scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      found_r      <= 1'b0;
      multi_r      <= 1'b0;
      hit_strobe_r <= 3'h0;
      hit_input_r  <= 2'h0;
    end else if (!run_w || scan_end_w) begin
      found_r <= 1'b0;
      multi_r <= 1'b0;
    end else if (sample_w) begin
      found_r      <= found_w;
      multi_r      <= multi_w;
      hit_strobe_r <= hit_strobe_w;
      hit_input_r  <= hit_input_w;
    end
  end

  // Command decision at the end of each scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r  <= 8'h00;
      tx_en_r <= 1'b0;
      sent_r  <= 1'b0;
      inval_r <= 1'b0;
    end else if (!run_w) begin
      tx_en_r <= 1'b0;
      sent_r  <= 1'b0;
    end else if (scan_end_w) begin
      inval_r <= multi_w;
      if (found_w && !multi_w) begin
        code_r  <= code_w;
        tx_en_r <= !(single_w && sent_r); // [RULE18] [RULE19]
        sent_r  <= single_w;
      end else begin
        tx_en_r <= 1'b0; // [RULE8]
      end
    end else if (tick_w && cyc_last_w) begin
      tx_en_r <= 1'b0;
    end
  end

  // Burst modulator
  logic [`IRT_CYC_W-1:0] tx_pos_w;
  logic [3:0]            bit_idx_w;
  logic [6:0]            slot_pos_w;
  logic                  bit_val_w;
  logic                  in_tx_w;

  assign in_tx_w    = (cyc_r >= `IRT_CYC_W'(SCAN_TICKS)) && (cyc_r < `IRT_CYC_W'(TX_END));
  assign tx_pos_w   = cyc_r - `IRT_CYC_W'(SCAN_TICKS);
  assign bit_idx_w  = tx_pos_w[10:7]; // [RULE23]
  assign slot_pos_w = tx_pos_w[6:0];
  assign bit_val_w  = bit_idx_w[3] ? ~code_r[bit_idx_w[2:0]]
                                   : code_r[bit_idx_w[2:0]]; // [RULE12] [RULE13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_r <= 1'b0;
    end else begin
      tx_r <= run_w && tx_en_r && in_tx_w && !slot_pos_w[0] // [RULE11] [RULE15]
              && (slot_pos_w < (bit_val_w ? 7'(`IRT_ONE_TICKS)
                                          : 7'(`IRT_ZERO_TICKS))); // [RULE14]
    end
  end

  // Strobe drive: all low in standby, one per slot during the scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_oe_n_r <= 8'h00; // [RULE1]
    end else if (!run_w) begin
      strobe_oe_n_r <= 8'h00;
    end else if (cyc_r < `IRT_CYC_W'(SCAN_TICKS)) begin
      strobe_oe_n_r <= ~(8'h01 << cyc_r[6:4]); // [RULE3]
    end else begin
      strobe_oe_n_r <= 8'hff;
    end
  end

  assign strobe_o         = 8'h00;
  assign strobe_oe_n      = strobe_oe_n_r;
  assign tx_out           = tx_r;
  assign txact_o          = 1'b0;
  assign txact_oe_n       = !tx_en_r; // [RULE10]
  assign osc_run          = run_w;
  assign pullup_en        = run_w;
  assign mode_pulldown_en = !run_w; // [RULE22]

  // APB slave, zero wait states
  logic mapped_w;
  assign mapped_w = (paddr == `IRT_REG_CTRL) || (paddr == `IRT_REG_STATUS)
                    || (paddr == `IRT_REG_CODE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= `IRT_CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == `IRT_REG_CTRL) begin
      ctrl_en_r <= pwdata[`IRT_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (paddr == `IRT_REG_CTRL) begin
        prdata_r[`IRT_CTRL_EN_BIT] <= ctrl_en_r;
      end else if (paddr == `IRT_REG_STATUS) begin
        prdata_r[`IRT_ST_STBY_BIT]  <= !run_w;
        prdata_r[`IRT_ST_TXACT_BIT] <= tx_en_r;
        prdata_r[`IRT_ST_SENT_BIT]  <= sent_r;
        prdata_r[`IRT_ST_INVAL_BIT] <= inval_r;
      end else if (paddr == `IRT_REG_CODE) begin
        prdata_r[7:0] <= code_r;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped_w;

  // Checks
  standby_strobes_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    !run_w && $past(!run_w) |-> strobe_oe_n == 8'h00)
    else $error("strobes not all driven in standby");

  key_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    !run_w && key_any_w && ctrl_en_r |=> run_w ##1 strobe_oe_n != 8'h00)
    else $error("key press did not wake the device");

  one_strobe_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    run_w && $past(run_w) |-> $countones(~strobe_oe_n) <= 1)
    else $error("more than one strobe active");

  tx_window_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    tx_out |-> $past(cyc_r) >= `IRT_CYC_W'(SCAN_TICKS)
               && $past(cyc_r) < `IRT_CYC_W'(TX_END))
    else $error("pulse outside the burst window");

  tx_active_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    tx_out |-> !txact_oe_n && !$past(txact_oe_n))
    else $error("pulse without active output");

  invalid_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    scan_end_w && multi_w |=> !tx_en_r)
    else $error("code sent after invalid scan");

  single_once_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
    scan_end_w && sent_r && single_w && run_w |=> !tx_en_r)
    else $error("single-shot code repeated");

  code_form_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    scan_end_w && found_w && !multi_w |=> code_r[7:5] == ~$past(shift_s_r))
    else $error("shift bits wrong in code");

  idle_standby_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    $fell(run_w) |-> $past(!ctrl_en_r || (scan_end_w && !found_w && !multi_w)))
    else $error("standby entered without an empty scan");

  apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !mapped_w |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule : irt_transmitter

// File: tb/irt_far_model.sv
/*
  Far-side model: key matrix answering the strobes, and an infrared
  receiver that counts pulses per burst and rebuilds the 16-bit frame.
  Assumes strobe_oe_n low drives a strobe and key inputs have pull-ups.
*/
`timescale 1ns/1ps

module irt_far_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  strobe_oe_n,
  input  wire logic [31:0] press,
  input  wire logic        tx_out,
  output logic      [3:0]  key_n,
  output logic      [7:0]  rx_code,
  output logic             rx_valid,
  output logic             rx_bad
);
  logic        tx_q;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  int          pulses;
  int          idle;
  int          nbits;

  // Key index is strobe*4+input; an open input floats high
  always_comb begin
    key_n = 4'hf;
    for (int s = 0; s < 8; s++) begin
      for (int i = 0; i < 4; i++) begin
        if (!strobe_oe_n[s] && press[s*4+i]) key_n[i] = 1'b0;
      end
    end
  end

  assign sh_nxt = {(pulses > 40), sh_r[15:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q     <= 1'b0;
      sh_r     <= 16'h0000;
      pulses   <= 0;
      idle     <= 0;
      nbits    <= 0;
      rx_code  <= 8'h00;
      rx_valid <= 1'b0;
      rx_bad   <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_q     <= tx_out;
      if (tx_out && !tx_q) begin
        pulses <= pulses + 1;
        idle   <= 0;
      end else if (idle < 1000) begin
        idle <= idle + 1;
      end
      // Silence closes a burst
      if (idle == 40 && pulses > 0) begin
        if (pulses != 32 && pulses != 48) rx_bad <= 1'b1;
        sh_r   <= sh_nxt;
        pulses <= 0;
        nbits  <= nbits + 1;
        if (nbits == 15) begin
          nbits    <= 0;
          rx_code  <= sh_nxt[7:0];
          rx_valid <= 1'b1;
          if (sh_nxt[15:8] !== ~sh_nxt[7:0]) rx_bad <= 1'b1;
        end
      end
      if (idle == 400) nbits <= 0;
    end
  end
endmodule : irt_far_model

// File: tb/tb_ir_remote_command_transmitter.sv
/*
  Bench: presses keys, reads registers over APB, decodes frames.
  Assumes TICK_DIV 2 and CYCLE_TICKS 2177 to keep the run short.
*/
`timescale 1ns/1ps
`include "irt_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module tb_ir_remote_command_transmitter;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        single_n, mode_sel, txact_oe_n, tx_out, osc_run, pullup_en;
  logic        mode_pulldown_en, rx_valid, rx_bad;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, press, seed, rd;
  logic [7:0]  strobe_oe_n, rx_code, exp_code;
  logic [3:0]  key_n;
  logic [2:0]  shift_n, sh;
  int          failures, check_count, frames;

  irt_transmitter #(.TICK_DIV(2), .CYCLE_TICKS(2177)) irt_transmitter_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_n(key_n), .shift_n(shift_n), .single_n(single_n), .mode_sel(mode_sel),
    .strobe_o(), .strobe_oe_n(strobe_oe_n), .txact_o(), .txact_oe_n(txact_oe_n),
    .tx_out(tx_out), .osc_run(osc_run), .pullup_en(pullup_en),
    .mode_pulldown_en(mode_pulldown_en));

  irt_far_model irt_far_model_inst (
    .pclk(pclk), .presetn(presetn), .strobe_oe_n(strobe_oe_n), .press(press),
    .tx_out(tx_out), .key_n(key_n), .rx_code(rx_code), .rx_valid(rx_valid),
    .rx_bad(rx_bad));

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic test_done();
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic to_standby();
    int n;
    n = 0;
    while (osc_run !== 1'b0 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    `CHK("osc_run", 1'b0, osc_run)
    `CHK("strobes", 8'h00, strobe_oe_n)
    `CHK("pullup", 1'b0, pullup_en)
    `CHK("pulldown", 1'b1, mode_pulldown_en)
    `CHK("txact idle", 1'b1, txact_oe_n)
    `CHK("tx idle", 1'b0, tx_out)
  endtask : to_standby

  task automatic press_keys(input logic [31:0] p);
    press   <= p;
    shift_n <= sh;
    frames = 0;
    repeat (6) @(posedge pclk);
    `CHK("wake", 1'b1, osc_run)
    `CHK("strobe release", 1'b1, strobe_oe_n !== 8'h00)
    `CHK("txact in scan", 1'b1, txact_oe_n)
  endtask : press_keys

  always @(posedge pclk) begin
    if (rx_valid === 1'b1) begin
      frames++;
      `CHK("code", exp_code, rx_code)
      `CHK("txact", 1'b0, txact_oe_n)
      `CHK("burst", 1'b0, rx_bad)
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    press = 32'h0;
    shift_n = 3'h7;
    single_n = 1'b1;
    mode_sel = 1'b1;
    seed = 32'h1f67;
    exp_code = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    to_standby();
    apb(1'b0, `IRT_REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    // Disabled block ignores a key press
    apb(1'b1, `IRT_REG_CTRL, 32'h0);
    apb(1'b0, `IRT_REG_CTRL, 32'h0);
    `CHK("ctrl off", 32'h0, rd)
    press <= 32'h1;
    repeat (8) @(posedge pclk);
    `CHK("disabled", 1'b0, osc_run)
    press <= 32'h0;
    apb(1'b1, `IRT_REG_CTRL, 32'h1);
    apb(1'b0, `IRT_REG_STATUS, 32'h0);
    `CHK("status", 32'h1, rd)
    apb(1'b1, `IRT_REG_CODE, 32'hff);
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b0, `IRT_REG_CODE, 32'h0);
    `CHK("code ro", 32'h0, rd)
    // Continuous, mode-select single-shot, single-shot pin
    for (int m = 0; m < 3; m++) begin
      seed = lfsr_next(seed);
      sh = seed[7:5];
      if (m == 1) sh[2] = 1'b0;
      single_n <= (m != 2);
      mode_sel <= (m != 1);
      exp_code = {~sh, seed[2:0], seed[4:3]};
      press_keys(32'h1 << {seed[2:0], seed[4:3]});
      repeat (9000) @(posedge pclk);
      `CHK("frames", (m == 0) ? 2 : 1, frames)
      apb(1'b0, `IRT_REG_CODE, 32'h0);
      `CHK("code reg", {24'h0, exp_code}, rd)
      apb(1'b0, `IRT_REG_STATUS, 32'h0);
      `CHK("sent flag", m != 0, rd[`IRT_ST_SENT_BIT])
      `CHK("running", 1'b0, rd[`IRT_ST_STBY_BIT])
      press <= 32'h0;
      to_standby();
    end
    // Two keys on different strobes
    seed = lfsr_next(seed);
    sh = 3'h7;
    press_keys((32'h1 << {seed[2:0], 2'd0}) | (32'h1 << {seed[2:0] + 3'd1, 2'd1}));
    repeat (5000) @(posedge pclk);
    `CHK("invalid frames", 0, frames)
    apb(1'b0, `IRT_REG_STATUS, 32'h0);
    `CHK("invalid flag", 1'b1, rd[`IRT_ST_INVAL_BIT])
    press <= 32'h0;
    to_standby();
    test_done();
  end
endmodule : tb_ir_remote_command_transmitter
